// [rtl/bcu_pkg.sv]
// Package with register map, field positions and reset values of the breakpoint compare unit.
package bcu_pkg;

    // ----------------------------------------------------------------
    // Register indices on the plain register port.
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_FIRST_CTRL = 4'h0;
    localparam logic [3:0] ADDR_FIRST_HIGH = 4'h1;
    localparam logic [3:0] ADDR_FIRST_LOW = 4'h2;
    localparam logic [3:0] ADDR_SECOND_CTRL = 4'h3;
    localparam logic [3:0] ADDR_SECOND_HIGH = 4'h4;
    localparam logic [3:0] ADDR_SECOND_LOW = 4'h5;
    localparam logic [3:0] ADDR_THIRD_CTRL = 4'h6;
    localparam logic [3:0] ADDR_THIRD_HIGH = 4'h7;
    localparam logic [3:0] ADDR_THIRD_LOW = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h9;

    // ----------------------------------------------------------------
    // Control register field positions.
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE = 7;
    localparam int BIT_DIR_ENABLE = 6;
    localparam int BIT_DIR_VALUE = 5;
    localparam int BIT_TAG = 4;
    localparam int BIT_FULL_ENABLE = 1;
    localparam int BIT_FULL_COND = 0;

    // Writable bits: first control has full mode bits, others do not.
    localparam logic [7:0] FIRST_CTRL_MASK = 8'hF3;
    localparam logic [7:0] OTHER_CTRL_MASK = 8'hF0;

    // ----------------------------------------------------------------
    // Status register field positions, and reset values of the control and compare registers.
    // ----------------------------------------------------------------
    localparam int BIT_FLAG_FIRST = 2;
    localparam int BIT_FLAG_SECOND = 1;
    localparam int BIT_FLAG_THIRD = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;

endpackage

// [rtl/bcu_breakpoint_compare_unit.sv]
// Breakpoint compare unit: three comparators, full mode, tag and force break requests.
// How it works
// - Three breakpoints, each requesting only while its enable bit is set.
// - Comparator A matches core address against its high and low registers.
// - Comparator B matches address, or data against its low register in full mode.
// - Comparator C matches core address against its high and low registers.
// - In full mode A's direction bits steer A and B; 1/0 means write.
// - In full mode comparator B's own direction bits are ignored.
// - A match raises a break request only when its enable bit is set.
// - Tag select 0 gives a force request, taken at next instruction boundary.
// - Tag select 1 marks the fetched opcode in the instruction queue.
// - Force request holds until background debug entry; only power-on reset clears it.
// - Full mode data compare uses data of the access A is matching.
// - Full mode enable and condition select live in A's control register.
// - A-and-B mode sets A and B flags only when both match.
// - A-and-not-B mode sets both flags when A matches and B does not.
// - Tag requests in full mode depend on comparator A alone.
// - Force requests in full mode combine A and B per condition.
// - The unit has no reset output path.
// - The unit has no interrupt output.
// - Match flags clear when the core returns to foreground.
// - Enable bits are forced to zero while the device is secure.
module bcu_breakpoint_compare_unit
    import bcu_pkg::*;
#(
    parameter int ADDR_WIDTH = 16,
    parameter int DATA_WIDTH = 8
) (
    input wire logic REF_CLK,                       // Core clock.
    input wire logic RESET,                         // Synchronous reset, active high, not power-on.
    input wire logic POR,                           // Power-on reset, active high.
    input wire logic [3:0] REG_ADDR,                // Register index.
    input wire logic [7:0] REG_WDATA,               // Register write data.
    input wire logic REG_WR,                        // Register write strobe.
    input wire logic REG_RD,                        // Register read strobe.
    output logic [7:0] REG_RDATA,                   // Register read data, one cycle after strobe.
    input wire logic SECURE,                        // Device is secured.
    input wire logic BUS_VALID,                     // Core bus cycle is valid this clock.
    input wire logic BUS_READ,                      // Core bus cycle is a read.
    input wire logic [ADDR_WIDTH-1:0] BUS_ADDR,     // Core address bus.
    input wire logic [DATA_WIDTH-1:0] BUS_WDATA,    // Core write data bus.
    input wire logic [DATA_WIDTH-1:0] BUS_RDATA,    // Core read data bus.
    input wire logic OPCODE_FETCH,                  // Current cycle fetches an opcode.
    input wire logic IN_BACKGROUND,                 // Core is in background debug mode.
    output logic FORCE_BREAK,                       // Force-type break request.
    output logic TAG_BREAK                          // Tag mark for the fetched opcode, one cycle.
);

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        logic [7:0] cmp_a_high;
        logic [7:0] cmp_a_low;
        logic [7:0] cmp_b_high;
        logic [7:0] cmp_b_low;
        logic [7:0] cmp_c_high;
        logic [7:0] cmp_c_low;
        logic flag_a;
        logic flag_b;
        logic flag_c;
        logic force_req;
        logic tag_req;
        logic in_bg;
        logic [7:0] rdata;
    } bcu_state_type;

    bcu_state_type state_reg;
    bcu_state_type state_next;

    // Address compare with optional direction qualification.
    function automatic logic addr_hit(input logic [7:0] high,
                                      input logic [7:0] low,
                                      input logic [ADDR_WIDTH-1:0] addr,
                                      input logic dir_en,
                                      input logic dir_val,
                                      input logic rd);
        logic [15:0] ref_addr;
        ref_addr = {high, low};
        addr_hit = (addr == ref_addr[ADDR_WIDTH-1:0]) && (!dir_en || (dir_val == rd));
    endfunction

    // Masks a control write, keeping the enable clear while secure.
    function automatic logic [7:0] ctrl_write(input logic [7:0] wd,
                                               input logic [7:0] mask,
                                               input logic sec);
        logic [7:0] v;
        v = wd & mask;
        if (sec) begin
            v[BIT_ENABLE] = 1'b0;
        end
        ctrl_write = v;
    endfunction

    // Packs the three match flags into the status layout.
    function automatic logic [7:0] status_byte(input logic fa,
                                               input logic fb,
                                               input logic fc);
        logic [7:0] s;
        s = 8'h00;
        s[BIT_FLAG_FIRST] = fa;
        s[BIT_FLAG_SECOND] = fb;
        s[BIT_FLAG_THIRD] = fc;
        status_byte = s;
    endfunction

    logic full_mode;
    logic full_cond_not;
    logic full_write;
    logic [DATA_WIDTH-1:0] full_data;
    logic hit_a;
    logic hit_b_addr;
    logic hit_b_data;
    logic hit_c;
    logic hit_b;
    logic full_pair;
    logic en_a;
    logic en_b;
    logic en_c;
    logic tag_a;
    logic tag_b;
    logic tag_c;
    logic force_a;
    logic force_b;
    logic force_c;
    logic [DATA_WIDTH-1:0] data_ref;

    // ----------------------------------------------------------------
    // Control decode.
    // ----------------------------------------------------------------
    always_comb begin
        full_mode = state_reg.ctrl_a[BIT_FULL_ENABLE];
        full_cond_not = state_reg.ctrl_a[BIT_FULL_COND];
        full_write = state_reg.ctrl_a[BIT_DIR_ENABLE] && !state_reg.ctrl_a[BIT_DIR_VALUE];
        full_data = full_write ? BUS_WDATA : BUS_RDATA;

        data_ref = state_reg.cmp_b_low[DATA_WIDTH-1:0];

        en_a = state_reg.ctrl_a[BIT_ENABLE] && !SECURE;
        en_b = state_reg.ctrl_b[BIT_ENABLE] && !SECURE;
        en_c = state_reg.ctrl_c[BIT_ENABLE] && !SECURE;

        tag_a = state_reg.ctrl_a[BIT_TAG];
        // In full mode comparator B follows the tag choice of comparator A.
        tag_b = full_mode ? tag_a : state_reg.ctrl_b[BIT_TAG];
        tag_c = state_reg.ctrl_c[BIT_TAG];
    end

    // ----------------------------------------------------------------
    // Comparators.
    // ----------------------------------------------------------------
    always_comb begin
        if (full_mode) begin
            // A's direction bits always qualify the cycle in full mode.
            hit_a = BUS_VALID && addr_hit(state_reg.cmp_a_high,
                state_reg.cmp_a_low,
                BUS_ADDR,
                1'b1,
                !full_write,
                BUS_READ);
        end else begin
            hit_a = BUS_VALID && addr_hit(state_reg.cmp_a_high,
                state_reg.cmp_a_low,
                BUS_ADDR,
                state_reg.ctrl_a[BIT_DIR_ENABLE],
                state_reg.ctrl_a[BIT_DIR_VALUE],
                BUS_READ);
        end

        hit_b_addr = BUS_VALID && addr_hit(state_reg.cmp_b_high,
            state_reg.cmp_b_low,
            BUS_ADDR,
            state_reg.ctrl_b[BIT_DIR_ENABLE],
            state_reg.ctrl_b[BIT_DIR_VALUE],
            BUS_READ);
        hit_b_data = (full_data == data_ref);

        hit_c = BUS_VALID && addr_hit(state_reg.cmp_c_high,
            state_reg.cmp_c_low,
            BUS_ADDR,
            state_reg.ctrl_c[BIT_DIR_ENABLE],
            state_reg.ctrl_c[BIT_DIR_VALUE],
            BUS_READ);

        hit_b = full_mode ? hit_b_data : hit_b_addr;
        full_pair = hit_a && (full_cond_not ? !hit_b_data : hit_b_data);
    end

    // ----------------------------------------------------------------
    // Force requests per comparator.
    // ----------------------------------------------------------------
    always_comb begin
        if (full_mode) begin
            // B has no request of its own; its data result joins A's.
            force_a = en_a && !tag_a && full_pair;
            force_b = 1'b0;
        end else begin
            force_a = en_a && !tag_a && hit_a;
            force_b = en_b && !tag_b && hit_b_addr;
        end

        force_c = en_c && !tag_c && hit_c;
    end

    // ----------------------------------------------------------------
    // Next state.
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.in_bg = IN_BACKGROUND;
        state_next.rdata = 8'h00;

        // ------------------------------------------------------------
        // Match flags; a new match wins over the foreground clear.
        // ------------------------------------------------------------
        if (state_reg.in_bg && !IN_BACKGROUND) begin
            state_next.flag_a = 1'b0;
            state_next.flag_b = 1'b0;
            state_next.flag_c = 1'b0;
        end

        if (full_mode) begin
            if (en_a && full_pair) begin
                state_next.flag_a = 1'b1;
                state_next.flag_b = 1'b1;
            end
        end else begin
            if (en_a && hit_a) begin
                state_next.flag_a = 1'b1;
            end
            if (en_b && hit_b) begin
                state_next.flag_b = 1'b1;
            end
        end

        if (en_c && hit_c) begin
            state_next.flag_c = 1'b1;
        end

        // ------------------------------------------------------------
        // Force request, held until background entry.
        // ------------------------------------------------------------
        if (IN_BACKGROUND) begin
            state_next.force_req = 1'b0;
        end else if (force_a || force_b || force_c) begin
            state_next.force_req = 1'b1;
        end

        // ------------------------------------------------------------
        // Tag mark for the opcode fetched this cycle.
        // ------------------------------------------------------------
        state_next.tag_req = OPCODE_FETCH && ((en_a && tag_a && hit_a)
            || (!full_mode && en_b && tag_b && hit_b_addr) || (en_c && tag_c && hit_c));

        // ------------------------------------------------------------
        // Register writes; unmapped indices are ignored.
        // ------------------------------------------------------------
        if (REG_WR) begin
            case (REG_ADDR)
                ADDR_FIRST_CTRL: begin
                    state_next.ctrl_a = ctrl_write(REG_WDATA, FIRST_CTRL_MASK, SECURE);
                end
                ADDR_SECOND_CTRL: begin
                    state_next.ctrl_b = ctrl_write(REG_WDATA, OTHER_CTRL_MASK, SECURE);
                end
                ADDR_THIRD_CTRL: begin
                    state_next.ctrl_c = ctrl_write(REG_WDATA, OTHER_CTRL_MASK, SECURE);
                end
                ADDR_FIRST_HIGH: begin
                    state_next.cmp_a_high = REG_WDATA;
                end
                ADDR_FIRST_LOW: begin
                    state_next.cmp_a_low = REG_WDATA;
                end
                ADDR_SECOND_HIGH: begin
                    state_next.cmp_b_high = REG_WDATA;
                end
                ADDR_SECOND_LOW: begin
                    state_next.cmp_b_low = REG_WDATA;
                end
                ADDR_THIRD_HIGH: begin
                    state_next.cmp_c_high = REG_WDATA;
                end
                ADDR_THIRD_LOW: begin
                    state_next.cmp_c_low = REG_WDATA;
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Secure state forbids every enable, whatever was written.
        // ------------------------------------------------------------
        if (SECURE) begin
            state_next.ctrl_a[BIT_ENABLE] = 1'b0;
            state_next.ctrl_b[BIT_ENABLE] = 1'b0;
            state_next.ctrl_c[BIT_ENABLE] = 1'b0;
        end

        // ------------------------------------------------------------
        // Read data stand for one cycle and are zero otherwise.
        // ------------------------------------------------------------
        if (REG_RD) begin
            case (REG_ADDR)
                ADDR_FIRST_CTRL: begin
                    state_next.rdata = state_reg.ctrl_a;
                end
                ADDR_SECOND_CTRL: begin
                    state_next.rdata = state_reg.ctrl_b;
                end
                ADDR_THIRD_CTRL: begin
                    state_next.rdata = state_reg.ctrl_c;
                end
                ADDR_FIRST_HIGH: begin
                    state_next.rdata = state_reg.cmp_a_high;
                end
                ADDR_FIRST_LOW: begin
                    state_next.rdata = state_reg.cmp_a_low;
                end
                ADDR_SECOND_HIGH: begin
                    state_next.rdata = state_reg.cmp_b_high;
                end
                ADDR_SECOND_LOW: begin
                    state_next.rdata = state_reg.cmp_b_low;
                end
                ADDR_THIRD_HIGH: begin
                    state_next.rdata = state_reg.cmp_c_high;
                end
                ADDR_THIRD_LOW: begin
                    state_next.rdata = state_reg.cmp_c_low;
                end
                ADDR_STATUS: begin
                    state_next.rdata = status_byte(state_reg.flag_a, state_reg.flag_b, state_reg.flag_c);
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers. Ordinary reset spares the pending force request.
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (POR) begin
            state_reg <= '0;
        end else if (RESET) begin
            state_reg <= '0;
            state_reg.force_req <= state_reg.force_req;
        end else begin
            state_reg <= state_next;
        end
    end

    // No reset or interrupt outputs exist on this unit.
    assign REG_RDATA = state_reg.rdata;
    assign FORCE_BREAK = state_reg.force_req;
    assign TAG_BREAK = state_reg.tag_req;

endmodule

// [test/bcu_core_model.sv]
// Core side model: data buses and background debug entry and exit.
module bcu_core_model (
    input wire logic clk, // Core clock.
    input wire logic go, // A bus cycle is under way.
    input wire logic rd, // The cycle is a read.
    input wire logic [7:0] data, // Data of the cycle.
    input wire logic halt, // Debugger asks for a halt.
    input wire logic leave, // Return to foreground.
    input wire logic hold, // Delays the next instruction boundary.
    input wire logic force_brk, // Force request from the unit.
    output logic [7:0] wdata, // Write data bus.
    output logic [7:0] rdata, // Read data bus.
    output logic in_bg // Core is in background debug.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic noise = 1'b0;
    logic in_bg_reg = 1'b0;
    always_ff @(posedge clk) begin
        noise <= ~noise;
        in_bg_reg <= !leave && (in_bg_reg || halt || (force_brk && !hold));
    end
    assign in_bg = in_bg_reg;
    // A bus not carrying this cycle's data flips every cycle so that stale data never matches by luck.
    assign wdata = (go && !rd) ? data : {8{noise}};
    assign rdata = (go && rd) ? data : {8{noise}};
endmodule

// [test/bcu_asserts.sv]
// Checker of the port behaviour of the breakpoint compare unit.
module bcu_asserts
    import bcu_pkg::*;
(
    input wire logic REF_CLK, // Core clock.
    input wire logic RESET, // Synchronous reset.
    input wire logic POR, // Power-on reset.
    input wire logic [3:0] REG_ADDR, // Register index.
    input wire logic REG_RD, // Read strobe.
    input wire logic [7:0] REG_RDATA, // Read data.
    input wire logic SECURE, // Secure state.
    input wire logic BUS_VALID, // Valid bus cycle.
    input wire logic OPCODE_FETCH, // Opcode fetch.
    input wire logic IN_BACKGROUND, // Background debug.
    input wire logic FORCE_BREAK, // Force request.
    input wire logic TAG_BREAK // Tag mark.
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET || POR);
    sequence secure_held;
        SECURE ##1 SECURE;
    endsequence
    chk_force_holds: assert property (disable iff (POR) FORCE_BREAK && !IN_BACKGROUND |=> FORCE_BREAK)
        else $error("force request dropped early");
    chk_por_clears: assert property (disable iff (1'b0) POR |=> !FORCE_BREAK && !TAG_BREAK)
        else $error("power-on reset left a request");
    chk_reset_quiet: assert property (disable iff (1'b0) RESET |=> !TAG_BREAK && REG_RDATA == 8'h00)
        else $error("outputs active in reset");
    chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");
    chk_force_cause: assert property ($rose(FORCE_BREAK) |-> $past(BUS_VALID))
        else $error("force request without a bus cycle");
    chk_tag_cause: assert property (TAG_BREAK |-> $past(BUS_VALID && OPCODE_FETCH))
        else $error("tag mark without an opcode fetch");
    chk_secure_quiet: assert property (secure_held |=> !TAG_BREAK && !$rose(FORCE_BREAK))
        else $error("request while secure");
    chk_secure_read: assert property (secure_held ##0 (REG_RD && REG_ADDR == ADDR_FIRST_CTRL)
        |=> !REG_RDATA[BIT_ENABLE])
        else $error("enable bit set while secure");
endmodule
bind bcu_breakpoint_compare_unit bcu_asserts u_chk (.REF_CLK, .RESET, .POR, .REG_ADDR, .REG_RD, .REG_RDATA,
    .SECURE, .BUS_VALID, .OPCODE_FETCH, .IN_BACKGROUND, .FORCE_BREAK, .TAG_BREAK);

// [test/bcu_breakpoint_compare_unit_tb_top.sv]
// Self-checking testbench of the breakpoint compare unit.
module bcu_breakpoint_compare_unit_tb_top
    import bcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, reset = 1'b1, por = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, secure = 1'b0;
    logic bus_valid = 1'b0, bus_read = 1'b0, fetch = 1'b0, halt = 1'b0, leave = 1'b0, hold = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, bus_data = 8'h00, reg_rdata, wdata, rdata;
    logic [15:0] bus_addr = 16'h0000;
    logic in_bg, force_break, tag_break;
    int n_mismatch = 0, checks_done = 0;
    bcu_breakpoint_compare_unit u_dut (
        .REF_CLK(ref_clk), .RESET(reset), .POR(por), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SECURE(secure), .BUS_VALID(bus_valid),
        .BUS_READ(bus_read), .BUS_ADDR(bus_addr), .BUS_WDATA(wdata), .BUS_RDATA(rdata), .OPCODE_FETCH(fetch),
        .IN_BACKGROUND(in_bg), .FORCE_BREAK(force_break), .TAG_BREAK(tag_break));
    bcu_core_model u_core (.clk(ref_clk), .go(bus_valid), .rd(bus_read), .data(bus_data), .halt(halt),
        .leave(leave), .hold(hold), .force_brk(force_break), .wdata(wdata), .rdata(rdata), .in_bg(in_bg));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask
    // One bus cycle, then the requests and flags; flags FF means they are not looked at.
    task automatic hit(input logic r, f, input logic [15:0] a, input logic [7:0] d, input logic [1:0] brk,
                       input logic [7:0] flags, input logic clr);
        @(posedge ref_clk);
        bus_valid <= 1'b1;
        bus_read <= r;
        fetch <= f;
        bus_addr <= a;
        bus_data <= d;
        @(posedge ref_clk);
        bus_valid <= 1'b0;
        #1 chk("tag and force", {6'h00, brk}, {6'h00, tag_break, force_break});
        if (flags !== 8'hFF) rd_chk(ADDR_STATUS, flags, "match flags");
        if (clr) begin
            halt <= 1'b1;
            repeat (3) @(posedge ref_clk);
            halt <= 1'b0;
            leave <= 1'b1;
            #1 chk("force after halt", 8'h00, {7'h00, force_break});
            @(posedge ref_clk);
            leave <= 1'b0;
            rd_chk(ADDR_STATUS, 8'h00, "flags in foreground");
        end
    endtask
    task automatic t_regs();
        for (int i = 0; i < 11; i++) rd_chk((i == 10) ? 4'hF : 4'(i), 8'h00, "reset value");
        wr(ADDR_FIRST_CTRL, 8'hFF);
        rd_chk(ADDR_FIRST_CTRL, FIRST_CTRL_MASK, "first control");
        wr(ADDR_SECOND_CTRL, 8'hFF);
        rd_chk(ADDR_SECOND_CTRL, OTHER_CTRL_MASK, "second control");
        wr(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00, "unmapped");
        wr(ADDR_FIRST_CTRL, 8'h00);
        wr(ADDR_SECOND_CTRL, 8'h00);
    endtask
    task automatic t_enable_b();
        wr(ADDR_SECOND_HIGH, 8'h20);
        wr(ADDR_SECOND_LOW, 8'h40);
        hit(0, 0, 16'h2040, 8'h00, 2'b00, 8'h00, 1);
        wr(ADDR_SECOND_CTRL, 8'h80);
        hit(0, 0, 16'h2041, 8'h00, 2'b00, 8'h00, 1);
        hit(0, 0, 16'h2040, 8'h00, 2'b01, 8'h02, 1);
    endtask
    task automatic t_tag_c();
        wr(ADDR_THIRD_HIGH, 8'h30);
        wr(ADDR_THIRD_CTRL, 8'h90);
        hit(1, 0, 16'h3000, 8'h00, 2'b00, 8'hFF, 1);
        hit(1, 1, 16'h3000, 8'h00, 2'b10, 8'hFF, 1);
        wr(ADDR_THIRD_CTRL, 8'h00);
    endtask
    task automatic t_full();
        wr(ADDR_FIRST_HIGH, 8'h12);
        wr(ADDR_FIRST_LOW, 8'h34);
        wr(ADDR_SECOND_LOW, 8'h5A);
        wr(ADDR_SECOND_CTRL, 8'hE0);
        wr(ADDR_FIRST_CTRL, 8'hC2);
        hit(0, 0, 16'h1234, 8'h5A, 2'b01, 8'h06, 1);
        hit(0, 0, 16'h1234, 8'h5B, 2'b00, 8'h00, 1);
        hit(0, 0, 16'h1235, 8'h5A, 2'b00, 8'h00, 1);
        hit(1, 0, 16'h1234, 8'h5A, 2'b00, 8'h00, 1);
        wr(ADDR_FIRST_CTRL, 8'h82);
        hit(1, 0, 16'h1234, 8'h5A, 2'b01, 8'h06, 1);
        wr(ADDR_FIRST_CTRL, 8'hC3);
        hit(0, 0, 16'h1234, 8'h5B, 2'b01, 8'h06, 1);
        hit(0, 0, 16'h1234, 8'h5A, 2'b00, 8'h00, 1);
        wr(ADDR_FIRST_CTRL, 8'hD3);
        hit(0, 1, 16'h1234, 8'h5A, 2'b10, 8'hFF, 1);
        wr(ADDR_SECOND_CTRL, 8'h00);
    endtask
    task automatic t_secure();
        wr(ADDR_FIRST_CTRL, 8'h80);
        secure <= 1'b1;
        rd_chk(ADDR_FIRST_CTRL, 8'h00, "enable while secure");
        hit(0, 0, 16'h1234, 8'h00, 2'b00, 8'h00, 1);
        secure <= 1'b0;
    endtask
    task automatic t_force_reset();
        hold <= 1'b1;
        wr(ADDR_FIRST_CTRL, 8'h80);
        hit(0, 0, 16'h1234, 8'h00, 2'b01, 8'h04, 0);
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        #1 chk("force after reset", 8'h01, {7'h00, force_break});
        rd_chk(ADDR_FIRST_CTRL, 8'h00, "control after reset");
        por <= 1'b1;
        @(posedge ref_clk);
        por <= 1'b0;
        #1 chk("force after power-on", 8'h00, {7'h00, force_break});
        hold <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        por <= 1'b0;
        t_regs();
        t_enable_b();
        t_tag_c();
        t_full();
        t_secure();
        t_force_reset();
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
